/* File: design/cid_pkg.sv */
// How it works
// - pc add: 23-bit immediate shifted left two, sign-extended, added to own address
// - low two address bits are cleared before the pc add
// - pc sum goes to register picked by translated 3-bit field
// - pc add in a delay slot still uses its own address
// - neither add raises overflow; carry out of bit 31 dropped
// - both adds wrap modulo two to the 32 and never trap
// - scaled 25-bit offset reaches any word address within 16 megabytes either side
// - 3-bit fields select only registers 2 to 7, 16 and 17
// - code 0 maps to 16, code 1 to 17, 2..7 unchanged
// - stack add: 6-bit immediate shifted two, zero-extended, plus register 29
// - register jump-link short slot: two 5-bit fields, 16-bit minor opcode
// - barrier variant of register jump-link, same layout, short slot
// - absolute jump-link short slot: 26-bit target, no register, no minor
package cid_pkg;
  localparam logic [5:0]  OP_PC_ADD      = 6'h1e;
  localparam logic [5:0]  OP_GROUP_A     = 6'h00;
  localparam logic [5:0]  OP_ABS_JL      = 6'h1d;
  localparam logic [5:0]  OP_SP_ADD16    = 6'h1b;
  localparam logic [15:0] MINOR_REG_JL   = 16'h4f3c;
  localparam logic [15:0] MINOR_REG_JLB  = 16'h5f3c;
  localparam int          MAJ_LSB        = 26;
  localparam int          PC_RS_LSB      = 23;
  localparam int          PC_IMM_W       = 23;
  localparam int          SP_RD_LSB      = 7;
  localparam int          SP_IMM_LSB     = 1;
  localparam int          SP_IMM_W       = 6;
  localparam int          RT_LSB         = 21;
  localparam int          RS5_LSB        = 16;
  localparam int          TGT_W          = 26;
  localparam logic [4:0]  SP_REG         = 5'h1d;
  localparam logic [4:0]  LINK_REG_ABS   = 5'h1f;
  localparam logic [31:0] SLOT16_BYTES   = 32'h0000_0006;
  typedef enum logic [2:0] {
    OP_NONE, OP_PCADD, OP_SPADD, OP_JLR, OP_JLRB, OP_JLABS
  } cid_op_t;
endpackage

/* File: design/cid_decode.sv */
`timescale 1ns/100ps
`default_nettype none
module cid_decode (
  input  wire logic        CLK,
  input  wire logic        RST_B,
  input  wire logic        CE,
  input  wire logic        IN_VALID,
  input  wire logic [31:0] IN_INSTR,
  input  wire logic [31:0] IN_PC,
  input  wire logic [31:0] IN_SP_VALUE,
  output logic             WR_EN,
  output logic [4:0]       WR_REG,
  output logic [31:0]      WR_DATA,
  output logic             JUMP_EN,
  output logic [31:0]      JUMP_TARGET,
  output logic [4:0]       JUMP_REG,
  output logic             HAZARD_BARRIER,
  output logic [2:0]       OP_KIND
);
  typedef struct packed {
    logic        wr_en;
    logic [4:0]  wr_reg;
    logic [31:0] wr_data;
    logic        jmp;
    logic [31:0] jtgt;
    logic [4:0]  jreg;
    logic        hb;
    cid_pkg::cid_op_t op;
  } cid_state_t;

  logic [1:0] rst_sync_q;
  logic       rst_b_int;
  cid_state_t s_q;
  cid_state_t s_d;

  // release reset through two flops so all state leaves reset on one edge
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_b_int = rst_sync_q[1];

  function automatic logic [4:0] xlat(input logic [2:0] code);
    if (code == 3'h0) begin
      xlat = 5'h10;
    end else if (code == 3'h1) begin
      xlat = 5'h11;
    end else begin
      xlat = {2'h0, code};
    end
  endfunction

  // reach check for the pc add: result must sit in the signed 25-bit span of its base
  function automatic logic in_reach(input logic [31:0] res, input logic [31:0] base);
    logic [31:0] diff;
    diff = res - base;
    in_reach = (diff[31:24] == 8'h00) || (diff[31:24] == 8'hff);
  endfunction

  logic [5:0]  major;
  logic [15:0] minor;
  logic [31:0] pc_base;
  logic [31:0] pc_off;
  logic [31:0] sp_off;
  logic [31:0] link_addr;
  assign major = IN_INSTR[cid_pkg::MAJ_LSB +: 6];
  assign minor = IN_INSTR[15:0];
  // own address always, even in a delay slot; low bits forced clear
  assign pc_base = {IN_PC[31:2], 2'h0};
  assign pc_off = {{7{IN_INSTR[cid_pkg::PC_IMM_W-1]}},
                   IN_INSTR[0 +: cid_pkg::PC_IMM_W], 2'h0};
  // zero-extended: this offset only ever climbs above the stack pointer
  assign sp_off = {24'h0, IN_INSTR[cid_pkg::SP_IMM_LSB +: cid_pkg::SP_IMM_W], 2'h0};
  // slot is assumed 16 bits: 4-byte jump plus 2-byte slot
  assign link_addr = IN_PC + cid_pkg::SLOT16_BYTES;

  always_comb begin
    s_d = s_q;
    s_d.wr_en = 1'b0;
    s_d.jmp = 1'b0;
    s_d.hb = 1'b0;
    s_d.op = cid_pkg::OP_NONE;
    if (IN_VALID) begin
      if (major == cid_pkg::OP_PC_ADD) begin
        s_d.op = cid_pkg::OP_PCADD;
        s_d.wr_en = 1'b1;
        s_d.wr_reg = xlat(IN_INSTR[cid_pkg::PC_RS_LSB +: 3]);
        s_d.wr_data = pc_base + pc_off;
      end else if (major == cid_pkg::OP_SP_ADD16) begin
        s_d.op = cid_pkg::OP_SPADD;
        s_d.wr_en = 1'b1;
        s_d.wr_reg = xlat(IN_INSTR[cid_pkg::SP_RD_LSB +: 3]);
        s_d.wr_data = IN_SP_VALUE + sp_off;
      end else if (major == cid_pkg::OP_GROUP_A &&
                   (minor == cid_pkg::MINOR_REG_JL ||
                    minor == cid_pkg::MINOR_REG_JLB)) begin
        s_d.op = (minor == cid_pkg::MINOR_REG_JLB) ?
                 cid_pkg::OP_JLRB : cid_pkg::OP_JLR;
        s_d.hb = (minor == cid_pkg::MINOR_REG_JLB);
        // register zero is hard-wired, so a zero link field writes nothing
        s_d.wr_en = (IN_INSTR[cid_pkg::RT_LSB +: 5] != 5'h00);
        s_d.wr_reg = IN_INSTR[cid_pkg::RT_LSB +: 5];
        s_d.wr_data = link_addr;
        s_d.jmp = 1'b1;
        s_d.jreg = IN_INSTR[cid_pkg::RS5_LSB +: 5];
        s_d.jtgt = 32'h0;
      end else if (major == cid_pkg::OP_ABS_JL) begin
        s_d.op = cid_pkg::OP_JLABS;
        s_d.wr_en = 1'b1;
        s_d.wr_reg = cid_pkg::LINK_REG_ABS;
        s_d.wr_data = link_addr;
        s_d.jmp = 1'b1;
        s_d.jreg = 5'h00;
        // target stays in the same 128 MB region as the link address past the slot
        s_d.jtgt = {link_addr[31:27], IN_INSTR[0 +: cid_pkg::TGT_W], 1'b0};
      end
    end
  end

  always_ff @(posedge CLK or negedge rst_b_int) begin
    if (!rst_b_int) begin
      s_q <= '0;
    end else if (CE) begin
      s_q <= s_d;
    end
  end

  assign WR_EN = s_q.wr_en;
  assign WR_REG = s_q.wr_reg;
  assign WR_DATA = s_q.wr_data;
  assign JUMP_EN = s_q.jmp;
  assign JUMP_TARGET = s_q.jtgt;
  assign JUMP_REG = s_q.jreg;
  assign HAZARD_BARRIER = s_q.hb;
  assign OP_KIND = s_q.op;

  pc_add_value_a: assert property (@(posedge CLK) disable iff (!rst_b_int)
    CE && IN_VALID && major == cid_pkg::OP_PC_ADD |=> WR_EN &&
    WR_DATA == {$past(IN_PC[31:2]), 2'h0} +
               {{7{$past(IN_INSTR[22])}}, $past(IN_INSTR[22:0]), 2'h0})
    else $error("pc add result wrong");
  pc_low_bits_a: assert property (@(posedge CLK) disable iff (!rst_b_int)
    OP_KIND == cid_pkg::OP_PCADD |-> WR_DATA[1:0] == 2'h0)
    else $error("pc add low bits set");
  pc_dest_xlat_a: assert property (@(posedge CLK) disable iff (!rst_b_int)
    CE && IN_VALID && major == cid_pkg::OP_PC_ADD && IN_INSTR[25:23] == 3'h0
    |=> WR_REG == 5'h10)
    else $error("pc add destination wrong");
  xlat_range_a: assert property (@(posedge CLK) disable iff (!rst_b_int)
    (OP_KIND == cid_pkg::OP_PCADD || OP_KIND == cid_pkg::OP_SPADD) |->
    (WR_REG inside {[5'h02:5'h07], 5'h10, 5'h11}))
    else $error("bad translated register");
  sp_add_value_a: assert property (@(posedge CLK) disable iff (!rst_b_int)
    CE && IN_VALID && major == cid_pkg::OP_SP_ADD16 |=> WR_EN &&
    WR_DATA == $past(IN_SP_VALUE) + {24'h0, $past(IN_INSTR[6:1]), 2'h0})
    else $error("stack add result wrong");
  jlr_decode_a: assert property (@(posedge CLK) disable iff (!rst_b_int)
    CE && IN_VALID && major == cid_pkg::OP_GROUP_A && IN_INSTR[15:0] == cid_pkg::MINOR_REG_JL
    |=> JUMP_EN && !HAZARD_BARRIER && JUMP_REG == $past(IN_INSTR[20:16]))
    else $error("register jump decode wrong");
  jlrb_barrier_a: assert property (@(posedge CLK) disable iff (!rst_b_int)
    HAZARD_BARRIER |-> JUMP_EN && OP_KIND == cid_pkg::OP_JLRB)
    else $error("barrier without jump");
  abs_link_a: assert property (@(posedge CLK) disable iff (!rst_b_int)
    CE && IN_VALID && major == cid_pkg::OP_ABS_JL |=> JUMP_EN && WR_REG == 5'h1f &&
    JUMP_TARGET[26:1] == $past(IN_INSTR[25:0]))
    else $error("absolute jump decode wrong");
  link_short_a: assert property (@(posedge CLK) disable iff (!rst_b_int)
    CE && IN_VALID && major == cid_pkg::OP_ABS_JL |=> WR_DATA == $past(IN_PC) + 32'h6)
    else $error("link address wrong");
  pc_wrap_a: assert property (@(posedge CLK) disable iff (!rst_b_int)
    CE && IN_VALID && major == cid_pkg::OP_PC_ADD && IN_PC == 32'hffff_fffc &&
    IN_INSTR[22:0] == 23'h1 |=> WR_DATA == 32'h0)
    else $error("pc add did not wrap");
  pc_xlat_one_a: assert property (@(posedge CLK) disable iff (!rst_b_int)
    CE && IN_VALID && major == cid_pkg::OP_PC_ADD && IN_INSTR[25:23] == 3'h1
    |=> WR_REG == 5'h11)
    else $error("pc add code one wrong");
  sp_dest_xlat_a: assert property (@(posedge CLK) disable iff (!rst_b_int)
    CE && IN_VALID && major == cid_pkg::OP_SP_ADD16 && IN_INSTR[9:7] == 3'h0
    |=> WR_REG == 5'h10)
    else $error("stack add destination wrong");
  pc_reach_a: assert property (@(posedge CLK) disable iff (!rst_b_int)
    CE && IN_VALID && major == cid_pkg::OP_PC_ADD
    |=> in_reach(WR_DATA, {$past(IN_PC[31:2]), 2'h0}))
    else $error("pc add out of reach");
  sp_zero_ext_a: assert property (@(posedge CLK) disable iff (!rst_b_int)
    CE && IN_VALID && major == cid_pkg::OP_SP_ADD16
    |=> (WR_DATA - $past(IN_SP_VALUE)) <= 32'h0000_00fc)
    else $error("stack add offset not zero-extended");
  jlr_link_a: assert property (@(posedge CLK) disable iff (!rst_b_int)
    CE && IN_VALID && major == cid_pkg::OP_GROUP_A && minor == cid_pkg::MINOR_REG_JL &&
    IN_INSTR[25:21] != 5'h00
    |=> WR_EN && WR_REG == $past(IN_INSTR[25:21]) && WR_DATA == $past(IN_PC) + 32'h6)
    else $error("register jump link wrong");
  link_zero_a: assert property (@(posedge CLK) disable iff (!rst_b_int)
    CE && IN_VALID && major == cid_pkg::OP_GROUP_A && minor == cid_pkg::MINOR_REG_JL &&
    IN_INSTR[25:21] == 5'h00
    |=> JUMP_EN && !WR_EN)
    else $error("link to register zero written");
  barrier_link_a: assert property (@(posedge CLK) disable iff (!rst_b_int)
    CE && IN_VALID && major == cid_pkg::OP_GROUP_A && minor == cid_pkg::MINOR_REG_JLB
    |=> JUMP_EN && HAZARD_BARRIER && WR_DATA == $past(IN_PC) + 32'h6 &&
    JUMP_REG == $past(IN_INSTR[20:16]))
    else $error("barrier jump decode wrong");
  reg_jump_tgt_a: assert property (@(posedge CLK) disable iff (!rst_b_int)
    (OP_KIND == cid_pkg::OP_JLR || OP_KIND == cid_pkg::OP_JLRB) |-> JUMP_TARGET == 32'h0)
    else $error("register jump carries a target");
  abs_region_a: assert property (@(posedge CLK) disable iff (!rst_b_int)
    OP_KIND == cid_pkg::OP_JLABS |->
    JUMP_REG == 5'h00 && !HAZARD_BARRIER && !JUMP_TARGET[0] &&
    JUMP_TARGET[31:27] == WR_DATA[31:27])
    else $error("absolute jump region wrong");
  idle_clear_a: assert property (@(posedge CLK) disable iff (!rst_b_int)
    CE && !IN_VALID |=> !WR_EN && !JUMP_EN && !HAZARD_BARRIER && OP_KIND == 3'h0)
    else $error("output left standing when idle");
  freeze_hold_a: assert property (@(posedge CLK) disable iff (!rst_b_int)
    !CE |=> $stable(WR_EN) && $stable(WR_DATA) && $stable(WR_REG) && $stable(OP_KIND))
    else $error("state moved with enable low");

  pc_cov_c: cover property (@(posedge CLK) OP_KIND == cid_pkg::OP_PCADD);
  jlr_cov_c: cover property (@(posedge CLK) OP_KIND == cid_pkg::OP_JLR);
  sp_cov_c: cover property (@(posedge CLK) OP_KIND == cid_pkg::OP_SPADD);
  jlrb_cov_c: cover property (@(posedge CLK) OP_KIND == cid_pkg::OP_JLRB);
  abs_cov_c: cover property (@(posedge CLK) OP_KIND == cid_pkg::OP_JLABS);
endmodule
`default_nettype wire

/* File: tb/cid_decode_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module cid_decode_tb_top;
  typedef struct packed {
    logic [31:0] instr;
    logic [31:0] pc;
    logic [31:0] sp;
    logic [2:0]  op;
    logic        wen;
    logic [4:0]  dst;
    logic [31:0] data;
    logic [31:0] tgt;
    logic [4:0]  jreg;
  } cid_row_t;
  logic        clk, rst_b, ce, vld, wr_en, jump_en, barrier;
  logic [31:0] instr, pc, sp, wr_data, jump_target;
  logic [4:0]  wr_reg, jump_reg;
  logic [2:0]  op_kind;
  int          num_errors = 0;
  int          check_count = 0;
  cid_row_t    rows [11];
  cid_decode dut (.CLK(clk), .RST_B(rst_b), .CE(ce), .IN_VALID(vld), .IN_INSTR(instr),
    .IN_PC(pc), .IN_SP_VALUE(sp), .WR_EN(wr_en), .WR_REG(wr_reg), .WR_DATA(wr_data),
    .JUMP_EN(jump_en), .JUMP_TARGET(jump_target), .JUMP_REG(jump_reg),
    .HAZARD_BARRIER(barrier), .OP_KIND(op_kind));
  task finish_test();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // register and data fields only mean something when the write is on
  task check_row(input cid_row_t r);
    chk(32'(op_kind), 32'(r.op));
    chk(32'(wr_en), 32'(r.wen));
    if (r.wen) chk(32'(wr_reg), 32'(r.dst));
    if (r.wen) chk(wr_data, r.data);
    chk(32'(jump_en), 32'(r.op > 3'h2));
    chk(32'(barrier), 32'(r.op == 3'h4));
    if (r.op > 3'h2) begin
      chk(jump_target, r.tgt);
      chk(32'(jump_reg), 32'(r.jreg));
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    #(40 * 1000);
    num_errors++;
    finish_test();
  end
  initial begin
    rst_b = 1'b0;
    ce = 1'b1;
    vld = 1'b0;
    instr = 32'h0;
    pc = 32'h0;
    sp = 32'h0;
    rows[0] = '{32'h78000001, 32'h00001003, 32'h0, 3'h1, 1'b1, 5'h10, 32'h00001004, 32'h0, 5'h0};
    rows[1] = '{32'h78ffffff, 32'h00000002, 32'h0, 3'h1, 1'b1, 5'h11, 32'hfffffffc, 32'h0, 5'h0};
    rows[2] = '{32'h7bbfffff, 32'hfffffff0, 32'h0, 3'h1, 1'b1, 5'h07, 32'h00ffffec, 32'h0, 5'h0};
    rows[3] = '{32'h79400000, 32'h01000000, 32'h0, 3'h1, 1'b1, 5'h02, 32'h0, 32'h0, 5'h0};
    rows[4] = '{32'h6c00007e, 32'h0, 32'hffffff10, 3'h2, 1'b1, 5'h10, 32'h0000000c, 32'h0, 5'h0};
    rows[5] = '{32'h6c000282, 32'h0, 32'h00000100, 3'h2, 1'b1, 5'h05, 32'h00000104, 32'h0, 5'h0};
    rows[6] = '{32'h03e44f3c, 32'h00002000, 32'h0, 3'h3, 1'b1, 5'h1f, 32'h00002006, 32'h0, 5'h04};
    rows[7] = '{32'h00495f3c, 32'h00000010, 32'h0, 3'h4, 1'b1, 5'h02, 32'h00000016, 32'h0, 5'h09};
    rows[8] = '{32'h74000123, 32'h80000000, 32'h0, 3'h5, 1'b1, 5'h1f, 32'h80000006,
                32'h80000246, 5'h0};
    // link register zero must not be written
    rows[9] = '{32'h00044f3c, 32'h0, 32'h0, 3'h3, 1'b0, 5'h0, 32'h0, 32'h0, 5'h04};
    // top of the address space: the sum wraps to zero
    rows[10] = '{32'h78000001, 32'hfffffffc, 32'h0, 3'h1, 1'b1, 5'h10, 32'h0, 32'h0, 5'h0};
    repeat (16) @(negedge clk);
    rst_b = 1'b1;
    repeat (3) @(negedge clk);
    // back to back rows, checking the previous one as the next goes in
    for (int i = 0; i <= 11; i++) begin
      if (i > 0) check_row(rows[i-1]);
      vld = (i < 11);
      if (i < 11) begin
        instr = rows[i].instr;
        pc = rows[i].pc;
        sp = rows[i].sp;
      end
      @(negedge clk);
    end
    chk(32'(wr_en), 32'h0);
    instr = 32'hfc000000;
    vld = 1'b1;
    @(negedge clk);
    chk(32'(op_kind), 32'h0);
    chk(32'(wr_en), 32'h0);
    instr = rows[0].instr;
    pc = rows[0].pc;
    @(negedge clk);
    ce = 1'b0;
    instr = rows[4].instr;
    sp = rows[4].sp;
    @(negedge clk);
    check_row(rows[0]);
    // second frozen edge so the hold is seen across two samples
    @(negedge clk);
    check_row(rows[0]);
    ce = 1'b1;
    vld = 1'b0;
    rst_b = 1'b0;
    #1;
    chk(32'(wr_en), 32'h0);
    chk(32'(op_kind), 32'h0);
    @(negedge clk);
    rst_b = 1'b1;
    repeat (3) @(negedge clk);
    chk(32'(wr_en), 32'h0);
    vld = 1'b1;
    @(negedge clk);
    check_row(rows[4]);
    finish_test();
  end
endmodule
`default_nettype wire
